// File: pkg/rcos_pkg.sv
// Shared constants and types of the relay command output supervisor
`default_nettype none
package rcos_pkg;
  //==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RELEASE_MS     = 16'h000a;
  localparam logic [15:0] SETTLE_MS      = 16'h000a;
  localparam logic [16:0] OVERRUN_MS     = 17'h00002;
  localparam int unsigned NUM_CH         = 16;
  //==========================================================================
  // Register offsets
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_CONFIG     = 12'h004;
  localparam logic [11:0] OFS_DATA       = 12'h008;
  localparam logic [11:0] OFS_DURATION   = 12'h00c;
  localparam logic [11:0] OFS_STATUS     = 12'h010;
  localparam logic [11:0] OFS_READBACK   = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h018;
  localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h01c;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h020;
  //==========================================================================
  // Fields and reset values
  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_ABORT     = 1;
  localparam int unsigned CTRL_SELFTEST  = 2;
  localparam int unsigned CFG_MODE       = 0;
  localparam int unsigned CFG_POLE       = 4;
  localparam int unsigned CFG_STROBE     = 6;
  localparam int unsigned CFG_SUPERVISED = 7;
  localparam int unsigned CFG_BASE       = 8;
  localparam logic [1:0]  POLE_ONE       = 2'h0;
  localparam logic [1:0]  POLE_TWO       = 2'h1;
  localparam logic [1:0]  POLE_ONE_HALF  = 2'h2;
  localparam logic [11:0] CONFIG_RST     = 12'h000;
  localparam logic [15:0] DURATION_RST   = 16'h0064;
  localparam int unsigned EV_DONE        = 0;
  localparam int unsigned EV_COIL        = 1;
  localparam int unsigned EV_MOFN        = 2;
  localparam int unsigned EV_READBACK    = 3;
  localparam int unsigned EV_OVERRUN     = 4;
  localparam int unsigned EV_DRIVER      = 5;
  localparam int unsigned EV_CONFIG      = 6;
  localparam int unsigned EV_SELFTEST    = 7;
  localparam logic [7:0]  FAULT_MASK     = 8'h7e;
  //==========================================================================
  // Types
  typedef enum logic [3:0] {
    single_command, double_command, regulation_step_command,
    setpoint_output_8bit, setpoint_output_16bit, bitstring_output_1bit,
    bitstring_output_2bit, bitstring_output_8bit, bitstring_output_16bit
  } rcos_mode_t;
  typedef enum logic [2:0] {
    st_selftest, st_idle, st_precheck, st_release,
    st_settle, st_hold, st_unstrobe, st_inhibit
  } rcos_state_t;
endpackage : rcos_pkg
`default_nettype wire

// File: src/rcos_timer.sv
// Tick driven down counter with optional auto reload
`default_nettype none
module rcos_timer #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         tick,
  input  wire logic         reload,
  // Status
  output logic              busy,
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] period;
    logic         busy;
    logic         expired;
  } rcos_tmr_t;

  rcos_tmr_t st;
  rcos_tmr_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.expired = 1'b0;
    if (clear)
    begin
      next_st.busy = 1'b0;
    end
    else if (load)
    begin
      next_st.count  = value;
      next_st.period = value;
      next_st.busy   = (value != '0);
    end
    else if (st.busy && tick)
    begin
      if (st.count <= W'(1))
      begin
        next_st.expired = 1'b1;
        next_st.count   = st.period;
        next_st.busy    = reload;
      end
      else
      begin
        next_st.count = W'(st.count - W'(1));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign busy    = st.busy;
  assign expired = st.expired;
endmodule : rcos_timer
`default_nettype wire

// File: src/rcos_top.sv
// Relay command output supervisor: APB registers, sequencer and output checks
//==========================================================================
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
module rcos_top #(
  parameter int unsigned TICK_CYC = rcos_pkg::TICK_CYCLES
) (
  // APB slave
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Relay channels
  output logic      [rcos_pkg::NUM_CH-1:0]   relay_drive,
  input  wire logic [rcos_pkg::NUM_CH-1:0]   relay_feedback,
  output logic                               strobe_relay,
  // Coil supply path
  output logic                               coil_release_relay,
  input  wire logic                          release_feedback,
  input  wire logic                          coil_supply_ok,
  // Indicators and interrupt
  output logic                               fault_led,
  output logic                               cmd_led,
  output logic                               irq
);
  import rcos_pkg::*;

  typedef struct packed {
    rcos_state_t  state;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [11:0]  cfg;
    logic [15:0]  data;
    logic [15:0]  duration;
    logic [15:0]  pattern;
    logic [4:0]   m_count;
    logic         use_strobe;
    logic [15:0]  relays;
    logic         coil_on;
    logic         strobe;
    logic         inhibit;
    logic [7:0]   irq_status;
    logic [7:0]   irq_enable;
    logic         irq;
    logic         fault_led;
    logic         cmd_led;
  } rcos_regs_t;

  rcos_regs_t  st;
  rcos_regs_t  next_st;
  logic        div_busy;
  logic        ms_tick;
  logic        ph_load;
  logic [15:0] ph_val;
  logic        ph_busy;
  logic        ph_exp;
  logic        wd_load;
  logic        wd_clr;
  logic [16:0] wd_val;
  logic        wd_exp;
  logic        start;
  logic        abort;
  logic        selftest;
  logic        kill;
  logic        stop;
  logic        done;
  logic [7:0]  events;
  logic [7:0]  clr;
  logic [16:0] built;

  //==========================================================================
  // Helpers
  function automatic logic [4:0] ones(input logic [15:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 16; i++)
      n = n + 5'(v[i]);
    return n;
  endfunction : ones

  // Returns {config error, relay pattern}
  function automatic logic [16:0] build_pattern(input logic [11:0] cfg,
                                                input logic [15:0] dat);
    logic [15:0] raw;
    logic        err;
    logic [31:0] wide;
    logic [1:0]  pole;
    logic        two;
    raw  = '0;
    err  = 1'b0;
    pole = cfg[CFG_POLE +: 2];
    two  = (pole == POLE_TWO);
    wide = '0;
    if (pole == 2'h3)
      err = 1'b1;
    unique case (rcos_mode_t'(cfg[CFG_MODE +: 4]))
      single_command:
        raw = two ? 16'h0003 : 16'h0001;
      double_command:
        raw = two ? (dat[0] ? 16'h000c : 16'h0003)
                  : (dat[0] ? 16'h0002 : 16'h0001);
      regulation_step_command:
      begin
        raw = two ? (dat[0] ? 16'h000c : 16'h0003)
                  : (dat[0] ? 16'h0002 : 16'h0001);
        if (pole == POLE_ONE_HALF)
          err = 1'b1;
      end
      setpoint_output_8bit:   raw = {8'h00, dat[7:0]};
      setpoint_output_16bit:  raw = dat;
      bitstring_output_1bit:  raw = {15'h0000, dat[0]};
      bitstring_output_2bit:  raw = {14'h0000, dat[1:0]};
      bitstring_output_8bit:  raw = {8'h00, dat[7:0]};
      bitstring_output_16bit: raw = dat;
      default:                err = 1'b1;
    endcase
    // Half pole relies on the external module switching process voltage
    if (pole == POLE_ONE_HALF && !cfg[CFG_SUPERVISED])
      err = 1'b1;
    wide = {16'h0000, raw} << cfg[CFG_BASE +: 4];
    // Channels pushed past the last relay would be silently lost
    if (wide[31:16] != '0)
      err = 1'b1;
    return {err, wide[15:0]};
  endfunction : build_pattern

  //==========================================================================
  // Timers
  rcos_timer #(.W(16)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (1'b0),
    .load    (!div_busy),
    .value   (16'(TICK_CYC)),
    .tick    (1'b1),
    .reload  (1'b1),
    .busy    (div_busy),
    .expired (ms_tick)
  );

  rcos_timer #(.W(16)) u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (1'b0),
    .load    (ph_load),
    .value   (ph_val),
    .tick    (ms_tick),
    .reload  (1'b0),
    .busy    (ph_busy),
    .expired (ph_exp)
  );

  rcos_timer #(.W(17)) u_watchdog (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (wd_clr),
    .load    (wd_load),
    .value   (wd_val),
    .tick    (ms_tick),
    .reload  (1'b0),
    .busy    (),
    .expired (wd_exp)
  );

  //==========================================================================
  // Registers and sequencer
  always_comb
  begin
    next_st  = st;
    ph_load  = 1'b0;
    ph_val   = SETTLE_MS;
    wd_load  = 1'b0;
    wd_clr   = 1'b0;
    wd_val   = '0;
    start    = 1'b0;
    abort    = 1'b0;
    selftest = 1'b0;
    kill     = 1'b0;
    stop     = 1'b0;
    done     = 1'b0;
    events   = '0;
    clr      = '0;
    built    = build_pattern(st.cfg, st.data);
    // One wait state: data and error are registered with pready
    next_st.pready  = psel & penable & ~st.pready;
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready)
    begin
      next_st.prdata = '0;
      case (paddr)
        OFS_CTRL, OFS_IRQ_CLEAR: next_st.prdata = '0;
        OFS_CONFIG:     next_st.prdata = {20'h00000, st.cfg};
        OFS_DATA:       next_st.prdata = {16'h0000, st.data};
        OFS_DURATION:   next_st.prdata = {16'h0000, st.duration};
        OFS_STATUS:     next_st.prdata = {27'h0000000, st.strobe, st.coil_on,
                                          coil_supply_ok, st.inhibit,
                                          st.state != st_idle && st.state != st_inhibit};
        OFS_READBACK:   next_st.prdata = {16'h0000, relay_feedback};
        OFS_IRQ_STATUS: next_st.prdata = {24'h000000, st.irq_status};
        OFS_IRQ_ENABLE: next_st.prdata = {24'h000000, st.irq_enable};
        default:        next_st.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && st.pready)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          start    = pwdata[CTRL_START];
          abort    = pwdata[CTRL_ABORT];
          selftest = pwdata[CTRL_SELFTEST];
        end
        OFS_CONFIG:     next_st.cfg = pwdata[11:0];
        OFS_DATA:       next_st.data = pwdata[15:0];
        OFS_DURATION:   next_st.duration = pwdata[15:0];
        OFS_IRQ_CLEAR:  clr = pwdata[7:0];
        OFS_IRQ_ENABLE: next_st.irq_enable = pwdata[7:0];
        default:        ;
      endcase
    end
    unique case (st.state)
      st_selftest:
      begin
        if (!ph_busy && !ph_exp)
          ph_load = 1'b1;
        if (ph_exp)
        begin
          // Idle drivers must read back dead; anything else is a stuck driver
          if (relay_feedback != '0 || release_feedback)
            kill = 1'b1;
          else
          begin
            events[EV_SELFTEST] = 1'b1;
            next_st.state = st_idle;
          end
        end
      end
      st_idle:
      begin
        if (selftest)
          next_st.state = st_selftest;
        else if (start)
        begin
          if (built[16])
            events[EV_CONFIG] = 1'b1;
          else
          begin
            next_st.pattern    = built[15:0];
            next_st.m_count    = ones(built[15:0]);
            next_st.use_strobe = st.cfg[CFG_STROBE] &&
              (st.cfg[CFG_MODE +: 4] == 4'(setpoint_output_8bit) ||
               st.cfg[CFG_MODE +: 4] == 4'(setpoint_output_16bit));
            next_st.state = st_precheck;
          end
        end
      end
      st_precheck:
      begin
        if (relay_feedback != '0 || release_feedback)
          kill = 1'b1;
        else if (!coil_supply_ok)
        begin
          events[EV_COIL] = 1'b1;
          next_st.state = st_idle;
        end
        else
        begin
          next_st.coil_on = 1'b1;
          ph_load = 1'b1;
          ph_val  = RELEASE_MS;
          next_st.state = st_release;
        end
      end
      st_release:
      begin
        if (ph_exp)
        begin
          if (!release_feedback)
            kill = 1'b1;
          else
          begin
            next_st.relays = st.pattern;
            ph_load = 1'b1;
            next_st.state = st_settle;
          end
        end
      end
      st_settle:
      begin
        if (ph_exp)
        begin
          if (ones(relay_feedback) != st.m_count)
          begin
            events[EV_MOFN] = 1'b1;
            stop = 1'b1;
          end
          else if (relay_feedback != st.pattern)
          begin
            events[EV_READBACK] = 1'b1;
            stop = 1'b1;
          end
          else
          begin
            next_st.strobe = st.use_strobe;
            ph_load = 1'b1;
            ph_val  = (st.duration == '0) ? 16'h0001 : st.duration;
            wd_load = 1'b1;
            wd_val  = 17'({1'b0, st.duration} + OVERRUN_MS);
            next_st.state = st_hold;
          end
        end
      end
      st_hold, st_unstrobe:
      begin
        if (ones(relay_feedback) != st.m_count)
        begin
          events[EV_MOFN] = 1'b1;
          stop = 1'b1;
        end
        else if (relay_feedback != st.pattern)
        begin
          events[EV_READBACK] = 1'b1;
          stop = 1'b1;
        end
        else if (ph_exp && st.state == st_hold && st.use_strobe)
        begin
          // Strobe falls a settle time before the data relays let go
          next_st.strobe = 1'b0;
          // Unstrobe settle must not be mistaken for an overrun
          wd_load = 1'b1;
          wd_val  = 17'({1'b0, SETTLE_MS} + OVERRUN_MS);
          ph_load = 1'b1;
          next_st.state = st_unstrobe;
        end
        else if (ph_exp)
          done = 1'b1;
      end
      st_inhibit:
        ;
    endcase
    if (!kill && (st.state == st_release || st.state == st_settle ||
                  st.state == st_hold || st.state == st_unstrobe))
    begin
      if (!coil_supply_ok)
      begin
        events[EV_COIL] = 1'b1;
        stop = 1'b1;
      end
      if (wd_exp)
      begin
        events[EV_OVERRUN] = 1'b1;
        stop = 1'b1;
      end
      if (abort)
        stop = 1'b1;
      if (st.state != st_release && !release_feedback)
        kill = 1'b1;
    end
    if (kill)
    begin
      events[EV_DRIVER] = 1'b1;
      next_st.inhibit   = 1'b1;
      next_st.state     = st_inhibit;
    end
    events[EV_DONE] = done & ~stop & ~kill;
    if (kill || stop || done)
    begin
      next_st.relays  = '0;
      next_st.strobe  = 1'b0;
      next_st.coil_on = 1'b0;
      wd_clr = 1'b1;
      if (!kill)
        next_st.state = st_idle;
    end
    // A new event beats a clear landing in the same cycle
    next_st.irq_status = (st.irq_status & ~clr) | events;
    next_st.irq        = |(next_st.irq_status & next_st.irq_enable);
    next_st.fault_led  = next_st.inhibit | !coil_supply_ok |
                         (|(next_st.irq_status & FAULT_MASK));
    next_st.cmd_led    = (next_st.relays != '0) | next_st.strobe;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{state: st_selftest, cfg: CONFIG_RST, duration: DURATION_RST, default: '0};
    else
      st <= next_st;
  end

  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign relay_drive        = st.relays;
  assign strobe_relay       = st.strobe;
  assign coil_release_relay = st.coil_on;
  assign fault_led          = st.fault_led;
  assign cmd_led            = st.cmd_led;
  assign irq                = st.irq;

  //==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_two_pole_pair: assert property (st.state == st_idle && start && !built[16] &&
    st.cfg[CFG_MODE +: 4] == 4'(single_command) && st.cfg[CFG_POLE +: 2] == POLE_TWO
    |=> ones(st.pattern) == 5'd2) else $error("two pole pattern not two relays");
  a_coil_cancel: assert property (st.relays != '0 && !coil_supply_ok
    |=> st.relays == '0) else $error("relays held without coil supply");
  a_release_after_check: assert property ($rose(st.coil_on)
    |-> $past(st.state) == st_precheck && $past(relay_feedback) == '0 && $past(coil_supply_ok))
    else $error("release closed without precheck");
  a_relays_need_release: assert property (st.relays != '0 |-> st.coil_on)
    else $error("relays driven with release open");
  a_inhibit_forever: assert property (st.inhibit
    |=> st.inhibit && st.relays == '0 && !st.coil_on)
    else $error("inhibit lost or output active");
  a_mofn_cancel: assert property (st.state == st_hold && ones(relay_feedback) != st.m_count
    |=> st.relays == '0 && st.irq_status[EV_MOFN]) else $error("count fault kept output");
  a_readback_cancel: assert property (st.state == st_hold && relay_feedback != st.pattern
    |=> st.relays == '0 && st.state != st_hold) else $error("readback fault kept output");
  a_overrun_flag: assert property (st.state == st_hold && wd_exp && release_feedback
    |=> st.state == st_idle && st.irq_status[EV_OVERRUN])
    else $error("overrun not flagged");
  a_driver_report: assert property ($rose(st.inhibit) |-> st.irq_status[EV_DRIVER])
    else $error("driver fault not reported");
  a_fault_indicator: assert property (st.inhibit || !$past(coil_supply_ok) |-> st.fault_led)
    else $error("fault led dark during fault");
  a_cmd_indicator: assert property (st.relays != '0 |-> st.cmd_led)
    else $error("command led dark while active");
  a_strobe_on_data: assert property ($rose(st.strobe)
    |-> st.relays == st.pattern && $past(st.relays) == st.pattern)
    else $error("strobe before data settled");
  a_irq_level: assert property (st.irq == (|(st.irq_status & st.irq_enable)))
    else $error("irq does not follow enabled status");

  c_done: cover property (st.irq_status[EV_DONE] && !$past(st.irq_status[EV_DONE]));
  c_strobe: cover property ($fell(st.strobe) && st.state == st_unstrobe);
  c_inhibit: cover property ($rose(st.inhibit));
  c_coil_cancel: cover property (st.relays != '0 && !coil_supply_ok);
endmodule : rcos_top
`default_nettype wire

// File: verification/rcos_relay_plant.sv
// Relay contact model answering the coil and release drives
`default_nettype none
module rcos_relay_plant (
  // Clock
  input  wire logic        pclk,
  // Drives and injected faults
  input  wire logic [15:0] relay_drive,
  input  wire logic        coil_release_relay,
  input  wire logic [15:0] stuck_mask,
  input  wire logic        release_stuck,
  // Contact readback
  output logic      [15:0] relay_feedback,
  output logic             release_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  //==========================================================================
  // Contacts lag the coils by one cycle, so no instant readback is assumed
  always_ff @(posedge pclk)
  begin
    relay_feedback   <= relay_drive ^ stuck_mask;
    release_feedback <= coil_release_relay & ~release_stuck;
  end
endmodule : rcos_relay_plant
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the relay command output supervisor
`default_nettype none
module testbench import rcos_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] relay_drive, relay_feedback, stuck_mask;
  logic        strobe_relay, coil_release_relay, release_feedback, coil_supply_ok;
  logic        fault_led, cmd_led, irq, release_stuck;
  int          bad_count, total_checks, n;
  //==========================================================================
  // Design and relay model
  rcos_top #(.TICK_CYC(4)) u_rcos_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .relay_drive(relay_drive),
    .relay_feedback(relay_feedback), .strobe_relay(strobe_relay),
    .coil_release_relay(coil_release_relay), .release_feedback(release_feedback),
    .coil_supply_ok(coil_supply_ok), .fault_led(fault_led), .cmd_led(cmd_led), .irq(irq));
  rcos_relay_plant u_rcos_relay_plant (.pclk(pclk), .relay_drive(relay_drive),
    .coil_release_relay(coil_release_relay), .stuck_mask(stuck_mask),
    .release_stuck(release_stuck), .relay_feedback(relay_feedback),
    .release_feedback(release_feedback));
  //==========================================================================
  // Helpers
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic hang(input string m);
    bad_count++;
    $display("BAD %0t timeout %s", $time, m);
    tally_and_finish();
  endtask : hang
  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 20)
      hang("apb");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in the same step
    @(posedge pclk);
  endtask : apb
  task automatic run(input logic [11:0] cfg, input logic [15:0] dat);
    apb(1'b1, OFS_CONFIG, {20'h0, cfg});
    apb(1'b1, OFS_DATA, {16'h0, dat});
    apb(1'b1, OFS_CTRL, 32'h1);
  endtask : run
  task automatic wait_drive(input logic on);
    for (n = 0; n < 300 && ((relay_drive !== 16'h0) != on); n++)
      @(posedge pclk);
    if (n == 300)
      hang("relays");
  endtask : wait_drive
  task automatic wait_strobe(input logic on);
    for (n = 0; n < 300 && strobe_relay !== on; n++)
      @(posedge pclk);
    if (n == 300)
      hang("strobe");
  endtask : wait_strobe
  task automatic wait_irq(input int b);
    for (int i = 0; i < 200; i++)
    begin
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      if (q[b] === 1'b1)
        return;
    end
    hang("irq status");
  endtask : wait_irq
  //==========================================================================
  // Scenarios
  task automatic t_reset;
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(q, {20'h0, CONFIG_RST}, "config reset");
    apb(1'b0, OFS_DURATION, 32'h0);
    chk(q, {16'h0, DURATION_RST}, "duration reset");
    apb(1'b1, 12'h040, 32'hffff);
    chk(e, 1'b1, "unmapped error");
    wait_irq(EV_SELFTEST);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    apb(1'b1, OFS_CTRL, 32'h4);
    wait_irq(EV_SELFTEST);
    apb(1'b1, OFS_DURATION, 32'h3);
    $display("done reset");
  endtask : t_reset
  task automatic t_single;
    apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
    run(12'h300, 16'h0);
    wait_drive(1'b1);
    chk(relay_drive, 16'h0008, "single relay");
    chk(coil_release_relay, 1'b1, "release closed");
    repeat (2) @(posedge pclk);
    chk(cmd_led, 1'b1, "cmd led");
    wait_irq(EV_DONE);
    chk(relay_drive, 16'h0, "relays off after duration");
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    $display("done single");
  endtask : t_single
  task automatic t_patterns;
    logic [11:0] c[9] = '{12'h411, 12'h412, 12'h407, 12'h008, 12'hf05, 12'h004, 12'h206,
                          12'h1a0, 12'h210};
    logic [15:0] d[9] = '{16'h1, 16'h1, 16'h5a, 16'h8001, 16'h1, 16'h1234, 16'h3, 16'h0,
                          16'h0};
    logic [15:0] x[9] = '{16'h00c0, 16'h00c0, 16'h05a0, 16'h8001, 16'h8000, 16'h1234,
                          16'h000c, 16'h0002, 16'h000c};
    for (int i = 0; i < 9; i++)
    begin
      run(c[i], d[i]);
      wait_drive(1'b1);
      chk(relay_drive, x[i], "pattern");
      wait_irq(EV_DONE);
      apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    end
    $display("done patterns");
  endtask : t_patterns
  task automatic t_strobe;
    run(12'h043, 16'h00a5);
    wait_drive(1'b1);
    chk(strobe_relay, 1'b0, "strobe early");
    wait_strobe(1'b1);
    chk(relay_drive, 16'h00a5, "setpoint under strobe");
    wait_strobe(1'b0);
    chk(relay_drive, 16'h00a5, "data held past strobe");
    wait_irq(EV_DONE);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    $display("done strobe");
  endtask : t_strobe
  task automatic t_faults;
    // Faults injected while the strobe shows the output is in hold
    for (int i = 0; i < 2; i++)
    begin
      run(12'h043, 16'h1);
      wait_strobe(1'b1);
      stuck_mask <= i ? 16'h0003 : 16'h0100;
      wait_drive(1'b0);
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(q[3:0], i ? 32'h8 : 32'h4, "hold check cancel");
      stuck_mask <= 16'h0;
      apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    end
    coil_supply_ok <= 1'b0;
    run(12'h000, 16'h0);
    chk(fault_led, 1'b1, "fault led coil");
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk({relay_drive, 15'h0, q[EV_COIL]}, 32'h1, "coil refused");
    coil_supply_ok <= 1'b1;
    apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    // Coil loss, then an abort, during output: both cut without done
    for (int i = 0; i < 2; i++)
    begin
      run(12'h000, 16'h0);
      wait_drive(1'b1);
      if (i == 0)
        coil_supply_ok <= 1'b0;
      else
        apb(1'b1, OFS_CTRL, 32'h2);
      wait_drive(1'b0);
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(q[1:0], i ? 32'h0 : 32'h2, "cancel without done");
      coil_supply_ok <= 1'b1;
      apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    end
    run(12'h020, 16'h0);
    wait_irq(EV_CONFIG);
    chk({relay_drive, coil_release_relay}, 32'h0, "half pole refused");
    apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    release_stuck <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      run(12'h000, 16'h0);
      repeat (80) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({relay_drive, q[1], fault_led}, {16'h0, 2'h3}, "inhibit");
      release_stuck <= 1'b0;
    end
    $display("done faults");
  endtask : t_faults
  //==========================================================================
  // Clock, reset and sequence
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {stuck_mask, release_stuck, coil_supply_ok} = {17'h0, 1'b1};
    {bad_count, total_checks} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_single();
    t_patterns();
    t_strobe();
    t_faults();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
